// ==== logic/aop_port.sv ====
// result output port: parallel, byte-wide and dual-line serial read-back
`timescale 1ns/1ps
module aop_port #(
    parameter logic [aop_pkg::CNT_W-1:0] STANDBY_N_CYC = aop_pkg::STANDBY_N_EXIT_CYC,
    parameter logic [aop_pkg::CNT_W-1:0] SHDN_CYC = aop_pkg::SHDN_EXIT_CYC
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic cs_n,
    input wire logic rd_sclk,
    input wire logic interface_family_select,
    input wire logic [aop_pkg::RES_W-1:0] result_bus_pins_i,
    output logic [aop_pkg::RES_W-1:0] result_bus_pins_o,
    output logic [aop_pkg::RES_W-1:0] result_bus_pins_oe,
    input wire logic [aop_pkg::NUM_CH-1:0][aop_pkg::RES_W-1:0] conv_results,
    input wire logic results_updated,
    input wire logic standby_n,
    input wire logic range_sel,
    input wire logic device_reset,
    output logic frontend_power_down,
    output logic core_power_down,
    output logic wake_settled,
    output logic reset_required
);
    // sync fields: bit 0 is the first stage, bit 1 the second
    typedef struct packed {
        logic [1:0] cs_s;
        logic [1:0] rd_s;
        logic [1:0] fam_s;
        logic [1:0] bsel_s;
        logic [1:0] hben_s;
        logic [1:0] standby_n_s;
        logic [1:0] rng_s;
        logic [1:0] rst_s;
        logic cs_q;
        logic rd_q;
        aop_pkg::aop_mode_t mode;
        logic [aop_pkg::CH_W-1:0] ch;
        logic ph;
        logic [aop_pkg::SER_W-1:0] sh_a;
        logic [aop_pkg::SER_W-1:0] sh_b;
        logic [aop_pkg::RES_W-1:0] bus_o;
        logic [aop_pkg::RES_W-1:0] bus_oe;
    } aop_port_st_t;

    aop_port_st_t r;
    aop_port_st_t n;

    aop_pwr_if pwr_bus ();

    function automatic aop_pkg::aop_mode_t decode_mode(
        input logic fam,
        input logic bsel
    );
        if (!fam) begin
            return aop_pkg::MODE_PAR;
        end else if (bsel) begin
            return aop_pkg::MODE_BYTE;
        end
        return aop_pkg::MODE_SER;
    endfunction : decode_mode

    // lowest channel of the group leaves first, msb first
    function automatic logic [aop_pkg::SER_W-1:0] load_group(
        input logic [aop_pkg::NUM_CH-1:0][aop_pkg::RES_W-1:0] res,
        input int base
    );
        logic [aop_pkg::SER_W-1:0] v;
        v = '0;
        for (int i = 0; i < aop_pkg::HALF_CH; i++) begin
            v[(aop_pkg::HALF_CH-1-i)*aop_pkg::RES_W +: aop_pkg::RES_W] =
                res[base+i];
        end
        return v;
    endfunction : load_group

    function automatic logic [aop_pkg::BYTE_W-1:0] pick_byte(
        input logic [aop_pkg::RES_W-1:0] word,
        input logic upper
    );
        return upper ? word[aop_pkg::RES_W-1 -: aop_pkg::BYTE_W]
                     : word[aop_pkg::BYTE_W-1:0];
    endfunction : pick_byte

    logic cs;
    logic rd;
    logic read_active;
    logic read_end;
    logic cs_fall;
    logic sclk_rise;
    logic upper;
    logic [aop_pkg::RES_W-1:0] cur;

    always_comb begin
        n = r;
        n.cs_s = {r.cs_s[0], cs_n};
        n.rd_s = {r.rd_s[0], rd_sclk};
        n.fam_s = {r.fam_s[0], interface_family_select};
        n.bsel_s = {r.bsel_s[0], result_bus_pins_i[aop_pkg::BIT_BSEL]};
        n.hben_s = {r.hben_s[0], result_bus_pins_i[aop_pkg::BIT_HBEN]};
        n.standby_n_s = {r.standby_n_s[0], standby_n};
        n.rng_s = {r.rng_s[0], range_sel};
        n.rst_s = {r.rst_s[0], device_reset};
        cs = r.cs_s[1];
        rd = r.rd_s[1];
        n.cs_q = cs;
        n.rd_q = rd;
        read_active = !cs && !rd;
        // a read ends when either select or strobe rises (they may be tied)
        read_end = !r.cs_q && !r.rd_q && (cs || rd);
        cs_fall = r.cs_q && !cs;
        sclk_rise = !cs && rd && !r.rd_q;
        cur = conv_results[r.ch];

        // mode follows the pins only outside a frame
        if (cs) begin
            n.mode = decode_mode(r.fam_s[1], r.bsel_s[1]);
        end

        if (results_updated) begin
            n.ch = aop_pkg::CH_FIRST;
            n.ph = 1'b0;
        end else if (read_end && r.mode == aop_pkg::MODE_PAR) begin
            n.ch = r.ch + aop_pkg::CH_STEP;
        end else if (read_end && r.mode == aop_pkg::MODE_BYTE) begin
            n.ph = !r.ph;
            if (r.ph) begin
                n.ch = r.ch + aop_pkg::CH_STEP;
            end
        end

        if (r.mode == aop_pkg::MODE_SER) begin
            if (cs_fall) begin
                n.sh_a = load_group(conv_results, 0);
                n.sh_b = load_group(conv_results, aop_pkg::HALF_CH);
            end else if (sclk_rise) begin
                // shift on serial clock rise; zeros follow the last bit
                n.sh_a = {r.sh_a[aop_pkg::SER_W-2:0], 1'b0};
                n.sh_b = {r.sh_b[aop_pkg::SER_W-2:0], 1'b0};
            end
        end

        upper = r.hben_s[1] ? !r.ph : r.ph;
        n.bus_o = '0;
        n.bus_oe = '0;
        case (r.mode)
            aop_pkg::MODE_PAR: begin
                if (read_active) begin
                    // one assignment serves bits 15 to 0
                    n.bus_o = cur;
                    n.bus_oe = '1;
                end
            end
            aop_pkg::MODE_BYTE: begin
                // bit 8 and bits 15 to 9 stay released in this mode
                if (read_active) begin
                    n.bus_o[aop_pkg::BYTE_W-1:0] =
                        pick_byte(cur, upper);
                    n.bus_oe[aop_pkg::BYTE_W-1:0] = '1;
                end
                n.bus_oe[aop_pkg::BIT_SER_B] = 1'b0;
            end
            aop_pkg::MODE_SER: begin
                // the host ties the other data pins low, so they stay inputs
                if (!cs) begin
                    n.bus_o[aop_pkg::BIT_SER_A] =
                        n.sh_a[aop_pkg::SER_W-1];
                    n.bus_o[aop_pkg::BIT_SER_B] =
                        n.sh_b[aop_pkg::SER_W-1];
                    n.bus_oe[aop_pkg::BIT_SER_A] = 1'b1;
                    n.bus_oe[aop_pkg::BIT_SER_B] = 1'b1;
                end
            end
            default: begin
                n.bus_oe = '0;
            end
        endcase
        if (cs) begin
            n.bus_oe = '0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            // select, strobe and standby idle high: a zero start would
            // fake a read, a channel step and a shutdown exit after reset
            r <= '0;
            r.cs_s <= '1;
            r.rd_s <= '1;
            r.standby_n_s <= '1;
            r.cs_q <= 1'b1;
            r.rd_q <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign pwr_bus.standby_n_lvl = r.standby_n_s[1];
    assign pwr_bus.range_lvl = r.rng_s[1];
    assign pwr_bus.reset_lvl = r.rst_s[1];

    aop_pwr_ctrl #(
        .STANDBY_N_CYC(STANDBY_N_CYC),
        .SHDN_CYC(SHDN_CYC)
    ) u_pwr (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pwr(pwr_bus.ctrl)
    );

    assign result_bus_pins_o = r.bus_o;
    assign result_bus_pins_oe = r.bus_oe;
    assign frontend_power_down = pwr_bus.frontend_pd;
    assign core_power_down = pwr_bus.core_pd;
    assign wake_settled = pwr_bus.settled;
    assign reset_required = pwr_bus.reset_needed;
endmodule : aop_port

// ==== common/aop_pkg.sv ====
// constants and types shared by the result output port and power control
package aop_pkg;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int NUM_CH = 8;
    localparam int HALF_CH = 4;
    localparam int RES_W = 16;
    localparam int BYTE_W = 8;
    localparam int CH_W = 3;
    localparam int SER_W = HALF_CH * RES_W;
    localparam int BIT_BSEL = 15;
    localparam int BIT_HBEN = 14;
    localparam int BIT_SER_B = 8;
    localparam int BIT_SER_A = 7;
    localparam int CNT_W = 22;
    localparam int STANDBY_N_EXIT_US = 100;
    localparam int SHDN_EXIT_MS = 13;
    localparam longint STANDBY_N_EXIT_PS = longint'(STANDBY_N_EXIT_US) * 64'd1000000;
    localparam longint SHDN_EXIT_PS = longint'(SHDN_EXIT_MS) * 64'd1000000000;
    // least times: round up to whole cycles
    localparam longint STANDBY_N_EXIT_CYC_L =
        (STANDBY_N_EXIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam longint SHDN_EXIT_CYC_L =
        (SHDN_EXIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [CNT_W-1:0] STANDBY_N_EXIT_CYC = STANDBY_N_EXIT_CYC_L[CNT_W-1:0];
    localparam logic [CNT_W-1:0] SHDN_EXIT_CYC = SHDN_EXIT_CYC_L[CNT_W-1:0];
    localparam logic [CNT_W-1:0] CNT_ONE = 22'h000001;
    localparam logic [CH_W-1:0] CH_FIRST = 3'h0;
    localparam logic [CH_W-1:0] CH_STEP = 3'h1;

    typedef enum logic [1:0] {
        MODE_PAR,
        MODE_BYTE,
        MODE_SER
    } aop_mode_t;

    typedef enum logic [2:0] {
        PWR_ON,
        PWR_STANDBY_N,
        PWR_SHDN,
        PWR_WAKE
    } aop_pwr_state_t;
endpackage : aop_pkg

// ==== common/aop_pwr_if.sv ====
// interface between the output port and the power control
`timescale 1ns/1ps
interface aop_pwr_if;
    logic standby_n_lvl;
    logic range_lvl;
    logic reset_lvl;
    logic frontend_pd;
    logic core_pd;
    logic settled;
    logic reset_needed;

    modport ctrl (
        input standby_n_lvl,
        input range_lvl,
        input reset_lvl,
        output frontend_pd,
        output core_pd,
        output settled,
        output reset_needed
    );

    modport port (
        output standby_n_lvl,
        output range_lvl,
        output reset_lvl,
        input frontend_pd,
        input core_pd,
        input settled,
        input reset_needed
    );
endinterface : aop_pwr_if

// ==== logic/aop_pwr_ctrl.sv ====
// standby and shutdown control with wake settle timing
`timescale 1ns/1ps
module aop_pwr_ctrl #(
    parameter logic [aop_pkg::CNT_W-1:0] STANDBY_N_CYC = aop_pkg::STANDBY_N_EXIT_CYC,
    parameter logic [aop_pkg::CNT_W-1:0] SHDN_CYC = aop_pkg::SHDN_EXIT_CYC
) (
    input wire logic core_clk,
    input wire logic rst_b,
    aop_pwr_if.ctrl pwr
);
    typedef struct packed {
        aop_pkg::aop_pwr_state_t state;
        logic [aop_pkg::CNT_W-1:0] cnt;
        logic fe_pd;
        logic core_pd;
        logic settled;
        logic rst_need;
    } aop_pwr_st_t;

    aop_pwr_st_t r;
    aop_pwr_st_t n;

    always_comb begin
        n = r;
        if (!pwr.standby_n_lvl) begin
            // entry is honoured in any state, mid frame or mid wake
            n.state = pwr.range_lvl ? aop_pkg::PWR_STANDBY_N
                                    : aop_pkg::PWR_SHDN;
            n.fe_pd = 1'b1;
            n.core_pd = !pwr.range_lvl;
            n.settled = 1'b0;
        end else begin
            case (r.state)
                aop_pkg::PWR_STANDBY_N: begin
                    n.state = aop_pkg::PWR_WAKE;
                    n.cnt = STANDBY_N_CYC;
                    n.fe_pd = 1'b0;
                    n.core_pd = 1'b0;
                end
                aop_pkg::PWR_SHDN: begin
                    n.state = aop_pkg::PWR_WAKE;
                    n.cnt = SHDN_CYC;
                    n.fe_pd = 1'b0;
                    n.core_pd = 1'b0;
                end
                aop_pkg::PWR_WAKE: begin
                    n.cnt = r.cnt - aop_pkg::CNT_ONE;
                    if (r.cnt == aop_pkg::CNT_ONE) begin
                        n.state = aop_pkg::PWR_ON;
                        n.settled = 1'b1;
                    end
                end
                aop_pkg::PWR_ON: begin
                    n.settled = 1'b1;
                end
                default: begin
                    n.state = aop_pkg::PWR_ON;
                end
            endcase
        end
        // a reset pulse clears the flag, but a new shutdown exit wins
        if (pwr.reset_lvl) begin
            n.rst_need = 1'b0;
        end
        if (pwr.standby_n_lvl && r.state == aop_pkg::PWR_SHDN) begin
            n.rst_need = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign pwr.frontend_pd = r.fe_pd;
    assign pwr.core_pd = r.core_pd;
    assign pwr.settled = r.settled;
    assign pwr.reset_needed = r.rst_need;
endmodule : aop_pwr_ctrl

// ==== bench/aop_port_props.sv ====
// assertions on the result port and power pins
`timescale 1ns/1ps
module aop_port_props #(
    parameter logic [aop_pkg::CNT_W-1:0] STANDBY_N_CYC = 22'h000014,
    parameter logic [aop_pkg::CNT_W-1:0] SHDN_CYC = 22'h000032
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic cs_n,
    input wire logic rd_sclk,
    input wire logic interface_family_select,
    input wire logic [aop_pkg::RES_W-1:0] result_bus_pins_i,
    input wire logic [aop_pkg::RES_W-1:0] result_bus_pins_oe,
    input wire logic standby_n,
    input wire logic range_sel,
    input wire logic frontend_power_down,
    input wire logic core_power_down,
    input wire logic wake_settled,
    input wire logic reset_required
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    wire fam = interface_family_select;
    wire b15 = result_bus_pins_i[15];
    wire [15:0] oe = result_bus_pins_oe;
    logic [21:0] wcnt_r;
    logic shdn_r;
    logic woke_r;
    // settle time counted from power-down release to settled
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wcnt_r <= '0;
            shdn_r <= 1'b0;
            woke_r <= 1'b0;
        end else begin
            wcnt_r <= (frontend_power_down || wake_settled) ? '0 :
                wcnt_r + aop_pkg::CNT_ONE;
            if (frontend_power_down) begin
                shdn_r <= core_power_down;
                woke_r <= 1'b1;
            end
        end
    end
    wire [21:0] tgt = shdn_r ? SHDN_CYC : STANDBY_N_CYC;
    wire in_win = (wcnt_r + 22'h000002 >= tgt) &&
        (wcnt_r <= tgt + 22'h000002);
    sequence s_par_rd;
        (!fam && !cs_n && !rd_sclk) [*4];
    endsequence
    sequence s_byte_rd;
        (fam && b15 && !cs_n && !rd_sclk) [*4];
    endsequence
    a_release_on_cs: assert property (cs_n [*4] |-> oe == 16'h0000)
        else $error("outputs still driven after select rise");
    a_release_on_rd: assert property (((!fam || b15) && rd_sclk) [*4]
        |-> oe == 16'h0000) else $error("driven with strobe high");
    a_par_full_drive: assert property (s_par_rd |-> oe == 16'hffff)
        else $error("parallel read not driving all pins");
    a_byte_low_only: assert property (s_byte_rd |-> oe == 16'h00ff)
        else $error("byte read drives wrong pins");
    a_serial_two_lines: assert property ((fam && !b15 && !cs_n) [*4]
        |-> oe == 16'h0180) else $error("serial drives wrong pins");
    a_standby_entry: assert property ((!standby_n && range_sel) [*4]
        |-> frontend_power_down && !core_power_down)
        else $error("standby state wrong");
    a_shutdown_entry: assert property ((!standby_n && !range_sel) [*4]
        |-> frontend_power_down && core_power_down)
        else $error("shutdown state wrong");
    a_settle_wait: assert property ($rose(wake_settled) && woke_r
        |-> in_win) else $error("settle time off");
    // a shutdown to standby step drops core power but is no recovery
    a_reset_flag_set: assert property ($fell(core_power_down) &&
        !frontend_power_down |-> ##[0:2] reset_required)
        else $error("no reset flag");
endmodule : aop_port_props

// ==== bench/aop_host.sv ====
// host controller model: select, strobe, serial clock, mode pins
`timescale 1ns/1ps
module aop_host (
    input wire logic core_clk,
    input wire logic [15:0] dev_o,
    input wire logic [15:0] dev_oe,
    output logic [15:0] pins,
    output logic cs_n,
    output logic rd_sclk,
    output logic fam
);
    logic [15:0] hmask = 16'h0000;
    logic [15:0] hval = 16'h0000;
    logic [15:0] last_r = 16'h0000;
    initial begin
        cs_n = 1'b1;
        rd_sclk = 1'b1;
        fam = 1'b0;
    end
    // floating pins show the inverse so stale data never looks valid
    assign pins = (dev_oe & dev_o) | (~dev_oe & hmask & hval) |
        (~dev_oe & ~hmask & ~last_r);
    always @(posedge core_clk) last_r <= pins;
    task automatic set_mode(input logic f, input logic b15, input logic b14);
        @(negedge core_clk);
        fam = f;
        hmask = !f ? 16'h0000 : (b15 ? 16'hc000 : 16'hfe7f);
        hval = {b15, b14, 14'h0000};
        repeat (6) @(negedge core_clk);
    endtask : set_mode
    task automatic strobe();
        @(negedge core_clk);
        cs_n = 1'b0;
        rd_sclk = 1'b0;
        repeat (8) @(negedge core_clk);
        cs_n = 1'b1;
        rd_sclk = 1'b1;
        repeat (6) @(negedge core_clk);
    endtask : strobe
    // serial clock idles high outside frames, drops low one cycle before select falls; phase unrelated to core
    task automatic ser_frame(output logic [63:0] a, output logic [63:0] b);
        @(negedge core_clk);
        rd_sclk = 1'b0;
        @(negedge core_clk);
        cs_n = 1'b0;
        for (int i = 0; i < 64; i++) begin
            #43;
            a = {a[62:0], pins[7]};
            b = {b[62:0], pins[8]};
            rd_sclk = 1'b1;
            #37;
            rd_sclk = 1'b0;
        end
        #3;
        cs_n = 1'b1;
        rd_sclk = 1'b1;
    endtask : ser_frame
endmodule : aop_host

// ==== bench/aop_port_test.sv ====
// self-checking bench for the result port and power control
`timescale 1ns/1ps
module aop_port_test;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic cs_n, rd_sclk, fam, upd = 1'b0, standby_n_n = 1'b1, rng = 1'b1;
    logic drst = 1'b0, fpd, cpd, ws, rr;
    logic [15:0] pins_i, pins_o, pins_oe, seed_r = 16'h0002;
    logic [7:0][15:0] res = '0;
    logic [63:0] sa, sb;
    logic [31:0] exp_q[$];
    int bad_count = 0;
    int num_checks = 0;
    always #2.5 core_clk = ~core_clk;
    aop_port #(.STANDBY_N_CYC(22'h000014), .SHDN_CYC(22'h000032)) aop_port_i (
        .core_clk(core_clk), .rst_b(rst_b), .cs_n(cs_n), .rd_sclk(rd_sclk),
        .interface_family_select(fam), .result_bus_pins_i(pins_i),
        .result_bus_pins_o(pins_o), .result_bus_pins_oe(pins_oe),
        .conv_results(res), .results_updated(upd), .standby_n(standby_n_n),
        .range_sel(rng), .device_reset(drst), .frontend_power_down(fpd),
        .core_power_down(cpd), .wake_settled(ws), .reset_required(rr));
    aop_host aop_host_i (.core_clk(core_clk), .dev_o(pins_o),
        .dev_oe(pins_oe), .pins(pins_i), .cs_n(cs_n), .rd_sclk(rd_sclk),
        .fam(fam));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    task automatic load();
        @(negedge core_clk);
        for (int c = 0; c < 8; c++) begin
            seed_r = lfsr(seed_r);
            res[c] = seed_r;
        end
        upd = 1'b1;
        @(negedge core_clk);
        upd = 1'b0;
    endtask : load
    task automatic wake();
        standby_n_n = 1'b1;
        for (int n = 0; n < 200 && ws !== 1'b1; n++) @(negedge core_clk);
        check("settled", {15'h0000, ws}, 16'h0001);
    endtask : wake
    always @(posedge pins_oe[0]) begin
        @(negedge core_clk);
        check("oe", pins_oe, exp_q[0][31:16]);
        check("data", pins_o & pins_oe, exp_q[0][15:0]);
        void'(exp_q.pop_front());
    end
    initial begin
        repeat (12) @(negedge core_clk);
        check("oe_rst", pins_oe, 16'h0000);
        rst_b = 1'b1;
        repeat (4) @(negedge core_clk);
        load();
        for (int k = 0; k < 9; k++) begin
            exp_q.push_back({16'hffff, res[k % 8]});
            aop_host_i.strobe();
        end
        for (int k = 0; k < 6; k++) begin
            if (k % 4 == 0) begin
                aop_host_i.set_mode(1'b1, 1'b1, k == 0);
                load();
            end
            exp_q.push_back({16'h00ff, 8'h00, (k[0] ^ (k > 3)) ?
                res[k / 2 % 2][7:0] : res[k / 2 % 2][15:8]});
            aop_host_i.strobe();
        end
        aop_host_i.set_mode(1'b1, 1'b0, 1'b0);
        load();
        aop_host_i.ser_frame(sa, sb);
        for (int c = 0; c < 4; c++) begin
            check("line_a", sa[63 - 16 * c -: 16], res[c]);
            check("line_b", sb[63 - 16 * c -: 16], res[c + 4]);
        end
        aop_host_i.set_mode(1'b0, 1'b0, 1'b0);
        standby_n_n = 1'b0;
        repeat (4) @(negedge core_clk);
        check("standby_n", {14'h0000, fpd, cpd}, 16'h0002);
        rng = 1'b0;
        repeat (4) @(negedge core_clk);
        check("shdn", {14'h0000, fpd, cpd}, 16'h0003);
        wake();
        check("rst_req", {15'h0000, rr}, 16'h0001);
        drst = 1'b1;
        repeat (4) @(negedge core_clk);
        drst = 1'b0;
        check("rst_clr", {15'h0000, rr}, 16'h0000);
        rng = 1'b1;
        standby_n_n = 1'b0;
        repeat (4) @(negedge core_clk);
        wake();
        check("rst_keep", {15'h0000, rr}, 16'h0000);
        tally_and_finish();
    end
    initial begin
        #200000;
        bad_count++;
        tally_and_finish();
    end
endmodule : aop_port_test
bind aop_port aop_port_props #(.STANDBY_N_CYC(STANDBY_N_CYC), .SHDN_CYC(SHDN_CYC))
    aop_port_props_i (.core_clk(core_clk), .rst_b(rst_b), .cs_n(cs_n),
    .rd_sclk(rd_sclk), .interface_family_select(interface_family_select),
    .result_bus_pins_i(result_bus_pins_i),
    .result_bus_pins_oe(result_bus_pins_oe), .standby_n(standby_n),
    .range_sel(range_sel), .frontend_power_down(frontend_power_down),
    .core_power_down(core_power_down), .wake_settled(wake_settled),
    .reset_required(reset_required));
